// ===== sacr_regs.vh
// Behaviour
// - a falling edge of convert_start_n while power_down_n is high starts a conversion and samples the input
// - start and read strobes count only while device select is low
// - result drivers enabled only while read and select are both low
// - busy_n is low while converting, high when idle
// - result is 12 bits, highest line most significant
// - busy_n falls within 110 ns of the start edge
// - result valid in output latches at least 20 ns before busy_n rises
// - starts are ignored while a conversion runs
// - approximation register clears at start, resolves bits msb first
// - finished word is loaded into the output latches at conversion end
`ifndef SACR_REGS_VH
`define SACR_REGS_VH
`define SACR_BITS          12
`define SACR_CLK_PERIOD_NS 10
`define SACR_CONV_NS       1600
`define SACR_CONV_CYC      ((`SACR_CONV_NS) / (`SACR_CLK_PERIOD_NS))
`define SACR_STEP_CYC      ((`SACR_CONV_CYC) / (`SACR_BITS + 1))
`define SACR_BUSY_MAX_NS   110
`define SACR_READY_NS      20
`define SACR_READY_CYC     (((`SACR_READY_NS) + (`SACR_CLK_PERIOD_NS) - 1) / (`SACR_CLK_PERIOD_NS))
`define SACR_WAKE_NS       350
`define SACR_WAKE_CYC      (((`SACR_WAKE_NS) + (`SACR_CLK_PERIOD_NS) - 1) / (`SACR_CLK_PERIOD_NS))
`endif

// ===== sacr_sync.v
`timescale 1ns/10ps
`default_nettype none
module sacr_sync
(
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire       clk_en,
    input  wire       async_in,
    output reg        sync_out
);
    reg meta_reg;
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            meta_reg <= 1'b1;
            sync_out <= 1'b1;
        end
        else if (clk_en)
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // sacr_sync
`default_nettype wire

// ===== sacr_core.v
`timescale 1ns/10ps
`default_nettype none
`include "sacr_regs.vh"
module sacr_core
(
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        clk_en,
    input  wire        chip_select_n,
    input  wire        convert_start_n,
    input  wire        read_n,
    input  wire        power_down_n,
    input  wire        compare_in,
    output reg         busy_n,
    output reg         sample_hold,
    output reg  [11:0] dac_word,
    output reg  [11:0] result_bits_out,
    output reg  [11:0] result_bits_oe
);
    // ****************************************
    // input synchronisers
    // ****************************************
    wire [3:0] raw_in;
    wire [3:0] sync_in;
    assign raw_in = {power_down_n, read_n, convert_start_n, chip_select_n};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_sync
            sacr_sync u_sync
            (
                .ref_clk  (ref_clk),
                .rst_n    (rst_n),
                .clk_en   (clk_en),
                .async_in (raw_in[gi]),
                .sync_out (sync_in[gi])
            );
        end
    endgenerate
    wire cs_s   = sync_in[0];
    wire cvt_s  = sync_in[1];
    wire rd_s   = sync_in[2];
    wire pwr_s  = sync_in[3];

    // ****************************************
    // conversion sequencer
    // ****************************************
    localparam [2:0]   ST_IDLE     = 3'h1;
    localparam [2:0]   ST_CONV     = 3'h2;
    localparam [2:0]   ST_DONE     = 3'h4;
    localparam integer STEP_LAST_I = `SACR_STEP_CYC - 1;
    localparam integer READY_I     = `SACR_READY_CYC;
    localparam integer WAKE_I      = `SACR_WAKE_CYC;
    localparam [8:0]   STEP_LAST   = STEP_LAST_I[8:0];
    localparam [8:0]   READY_LAST  = READY_I[8:0];
    localparam [5:0]   WAKE_LAST   = WAKE_I[5:0];

    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [8:0]  step_reg;
    reg  [8:0]  step_next;
    reg  [3:0]  bit_reg;
    reg  [3:0]  bit_next;
    reg         cvt_prev_reg;
    reg  [5:0]  wake_reg;
    reg  [11:0] sar_reg;
    wire [11:0] sar_next;
    wire [11:0] dac_next;
    wire        start_edge;
    wire        step_end;
    wire        conv_start;
    wire        bit_decide;
    wire        conv_finish;
    wire        ready_done;
    wire        awake;

    assign start_edge  = cvt_prev_reg & ~cvt_s & ~cs_s & pwr_s;
    assign step_end    = (step_reg == STEP_LAST);
    assign conv_start  = (state_reg == ST_IDLE) & start_edge;
    assign bit_decide  = (state_reg == ST_CONV) & step_end;
    assign conv_finish = bit_decide & (bit_reg == 4'h0);
    assign ready_done  = (state_reg == ST_DONE) & (step_reg == READY_LAST);
    // wake-up wait is the host's duty; the counter only tracks readiness
    assign awake       = (wake_reg == WAKE_LAST);

    // ****************************************
    // start edge detect and wake-up tracking
    // ****************************************
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cvt_prev_reg <= 1'b1;
            wake_reg     <= 6'h00;
        end
        else if (clk_en)
        begin
            cvt_prev_reg <= cvt_s;
            if (!pwr_s)
                wake_reg <= 6'h00;
            else if (!awake)
                wake_reg <= wake_reg + 6'h01;
        end
    end

    // ****************************************
    // sequencer next state
    // ****************************************
    always @*
    begin
        state_next = state_reg;
        step_next  = step_reg;
        bit_next   = bit_reg;
        case (state_reg)
            ST_IDLE:
            begin
                step_next = 9'h000;
                if (start_edge)
                begin
                    state_next = ST_CONV;
                    bit_next   = 4'hb;
                end
            end
            ST_CONV:
            begin
                // further start edges are not looked at here
                if (step_end)
                begin
                    step_next = 9'h000;
                    if (bit_reg == 4'h0)
                        state_next = ST_DONE;
                    else
                        bit_next = bit_reg - 4'h1;
                end
                else
                    step_next = step_reg + 9'h001;
            end
            ST_DONE:
            begin
                // latch settles a few cycles before busy rises
                if (step_reg == READY_LAST)
                begin
                    state_next = ST_IDLE;
                    step_next  = 9'h000;
                end
                else
                    step_next = step_reg + 9'h001;
            end
            default:
            begin
                state_next = ST_IDLE;
                step_next  = 9'h000;
                bit_next   = 4'h0;
            end
        endcase
    end

    // ****************************************
    // sequencer registers
    // ****************************************
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            step_reg  <= 9'h000;
            bit_reg   <= 4'h0;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
            step_reg  <= step_next;
            bit_reg   <= bit_next;
        end
    end

    // ****************************************
    // approximation bits
    // ****************************************
    genvar bi;
    generate
        for (bi = 0; bi < 12; bi = bi + 1)
        begin : g_bit
            wire pick  = bit_decide & (bit_reg == bi);
            wire lower = bit_decide & (bit_reg == bi + 1);
            assign sar_next[bi] = conv_start ? 1'b0 :
                                  (pick ? compare_in : sar_reg[bi]);
            assign dac_next[bi] = conv_start ? ((bi == 11) ? 1'b1 : 1'b0) :
                                  (pick ? compare_in : (lower ? 1'b1 : dac_word[bi]));
        end
    endgenerate

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sar_reg  <= 12'h000;
            dac_word <= 12'h000;
        end
        else if (clk_en)
        begin
            sar_reg  <= sar_next;
            dac_word <= dac_next;
        end
    end

    // ****************************************
    // output latches
    // ****************************************
    always @(posedge ref_clk)
    begin
        if (!rst_n)
            result_bits_out <= 12'h000;
        else if (clk_en)
        begin
            // previous word stays until the last bit is decided
            if (conv_finish)
                result_bits_out <= sar_next;
        end
    end

    // ****************************************
    // status and sample-hold
    // ****************************************
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            busy_n      <= 1'b1;
            sample_hold <= 1'b0;
        end
        else if (clk_en)
        begin
            if (conv_start)
            begin
                busy_n      <= 1'b0;
                sample_hold <= 1'b1;
            end
            else if (ready_done)
            begin
                busy_n      <= 1'b1;
                sample_hold <= 1'b0;
            end
        end
    end

    // ****************************************
    // read drivers
    // ****************************************
    always @(posedge ref_clk)
    begin
        if (!rst_n)
            result_bits_oe <= 12'h000;
        else if (clk_en)
            result_bits_oe <= (!rd_s && !cs_s) ? 12'hfff : 12'h000;
    end
endmodule // sacr_core
`default_nettype wire

// ===== sacr_cmp_model.sv
`timescale 1ns/10ps
`default_nettype none
module sacr_cmp_model
(
    input  wire logic [11:0] dac_word,
    input  wire logic [11:0] level,
    output wire logic        keep
);
    assign keep = dac_word <= level;
endmodule // sacr_cmp_model
`default_nettype wire

// ===== sacr_core_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module sacr_core_asserts
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic        chip_select_n,
    input wire logic        convert_start_n,
    input wire logic        read_n,
    input wire logic        power_down_n,
    input wire logic        busy_n,
    input wire logic [11:0] dac_word,
    input wire logic [11:0] result_bits_out,
    input wire logic [11:0] result_bits_oe
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n || !clk_en);
    wire st = !(convert_start_n | chip_select_n);
    wire rd = !(read_n | chip_select_n);
    a_start_edge: assert property ($fell(busy_n) |-> $past(st, 2)) else $error("start");
    a_busy_soon: assert property ($rose(st) && busy_n && power_down_n &&
        $past(power_down_n, 3) |-> ##[1:11] !busy_n)
        else $error("slow");
    a_busy_hold: assert property ($fell(busy_n) |-> ##146 !busy_n) else $error("cut");
    a_data_ready: assert property ($rose(busy_n) |-> $stable(result_bits_out))
        else $error("late");
    a_busy_end: assert property ($fell(busy_n) |-> ##[150:170] busy_n)
        else $error("stuck");
    a_msb_first: assert property ($fell(busy_n) |-> dac_word == 12'h800)
        else $error("msb");
    a_load_end: assert property ($changed(result_bits_out) |-> !busy_n ##[1:4] busy_n)
        else $error("load");
    a_drive_on: assert property ($past(rd, 3) && $past(rd, 4) |-> &result_bits_oe)
        else $error("on");
    a_drive_off: assert property (!$past(rd, 3) && !$past(rd, 4) |-> ~|result_bits_oe)
        else $error("off");
    c_conv: cover property ($rose(busy_n));
    c_read: cover property (&result_bits_oe);
    c_retry: cover property (!busy_n && $rose(st));
endmodule // sacr_core_asserts
bind sacr_core sacr_core_asserts i_sacr_core_asserts (.ref_clk(ref_clk), .rst_n(rst_n),
    .clk_en(clk_en), .chip_select_n(chip_select_n), .convert_start_n(convert_start_n),
    .read_n(read_n), .power_down_n(power_down_n), .busy_n(busy_n), .dac_word(dac_word),
    .result_bits_out(result_bits_out), .result_bits_oe(result_bits_oe));
`default_nettype wire

// ===== sacr_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "sacr_regs.vh"
module sacr_core_tb;
    localparam int BUSY_CYC = 3 + `SACR_BITS * `SACR_STEP_CYC + `SACR_READY_CYC + 1;
    logic        ref_clk = 0, rst_n = 0, en = 1, pd_n = 1, sh;
    logic        cs_n = 1, st_n = 1, rd_n = 1, cmp, busy_n;
    logic [11:0] ain = 0, last = 0, dac, res, oe;
    logic [11:0] vals [4] = '{12'hfff, 12'h000, 12'ha5c, 12'h001};
    int          bad_count = 0, total_checks = 0, n;
    always #5 ref_clk = ~ref_clk;
    sacr_cmp_model i_sacr_cmp_model (.dac_word(dac), .level(ain), .keep(cmp));
    sacr_core i_sacr_core (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(en), .chip_select_n(cs_n),
        .convert_start_n(st_n), .read_n(rd_n), .power_down_n(pd_n), .compare_in(cmp),
        .busy_n(busy_n), .sample_hold(sh), .dac_word(dac), .result_bits_out(res),
        .result_bits_oe(oe));
    task chk(input string nm, input logic [12:0] seen, exp);
        total_checks++;
        bad_count += int'(seen !== exp);
        if (seen !== exp)
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
    endtask
    task go(input logic [11:0] v);
        ain = v;
        cs_n = 0;
        @(negedge ref_clk) st_n = 0;
        repeat (5) @(negedge ref_clk);
        chk("started", {busy_n, sh, 11'h000}, 13'h0800);
        st_n = 1;
        repeat (5) @(negedge ref_clk);
        st_n = 0;
        repeat (5) @(negedge ref_clk);
        chk("held", {busy_n, res}, {1'b0, last});
        for (n = 0; n < 200 && busy_n !== 1'b1; n++) @(negedge ref_clk);
        chk("span", 13'(n), 13'(BUSY_CYC - 15));
        chk("released", {busy_n, sh, 11'h000}, 13'h1000);
        st_n = 1;
        rd_n = 0;
        repeat (4) @(negedge ref_clk);
        chk("data", {oe[0], res}, {1'b1, v});
        cs_n = 1;
        st_n = 0;
        last = v;
        repeat (20) @(negedge ref_clk);
        chk("unselected", {busy_n, oe}, 13'h1000);
        st_n = 1;
        rd_n = 1;
        repeat (30) @(negedge ref_clk);
    endtask
    task doze;
        pd_n = 0;
        cs_n = 0;
        @(negedge ref_clk) st_n = 0;
        repeat (20) @(negedge ref_clk);
        chk("asleep", {busy_n, oe}, 13'h1000);
        st_n = 1;
        pd_n = 1;
        repeat (`SACR_WAKE_CYC) @(negedge ref_clk);
    endtask
    task stall(input logic [11:0] v);
        ain = v;
        cs_n = 0;
        @(negedge ref_clk) st_n = 0;
        repeat (20) @(negedge ref_clk);
        en = 0;
        repeat (30) @(negedge ref_clk);
        chk("frozen", {busy_n, res}, {1'b0, last});
        en = 1;
        for (n = 0; n < 250 && busy_n !== 1'b1; n++) @(negedge ref_clk);
        chk("stretch", 13'(n), 13'(BUSY_CYC - 20));
        st_n = 1;
        rd_n = 0;
        repeat (4) @(negedge ref_clk);
        chk("late", {oe[0], res}, {1'b1, v});
        last = v;
        rd_n = 1;
        cs_n = 1;
        repeat (30) @(negedge ref_clk);
    endtask
    task end_sim(input int late);
        bad_count += late;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(negedge ref_clk);
        rst_n = 1;
        foreach (vals[i]) go(vals[i]);
        doze;
        go(12'h3c7);
        stall(12'h5a5);
        end_sim(0);
    end
    initial #40000 end_sim(1);
endmodule // sacr_core_tb
`default_nettype wire
